//--- testbench/host_socket_model.sv
// host side model: drives chip enables, address and strobes one cycle at a time
`timescale 1ns/1ps
`default_nettype none

module host_socket_model
(
  input wire logic clk_sys,
  input wire logic wait_n,
  input wire logic [15:0] data_out,
  input wire logic [1:0] data_oe_n,
  output logic reg_n,
  output logic ce1_n,
  output logic ce2_n,
  output logic oe_n,
  output logic we_n,
  output logic iord_n,
  output logic iowr_n,
  output logic [10:0] addr,
  output logic [15:0] data_in,
  output int hangs
);
  initial
  begin
    {reg_n, ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n} = 7'h7f;
    addr = 11'h000;
    data_in = 16'h0000;
    hangs = 0;
  end

  // ce encoding is {ce2_n, ce1_n}; the host decodes the upper address itself
  task automatic access(input logic io, input logic wr, input logic [1:0] ce, input logic [10:0] a,
      input logic [15:0] wd, output logic [15:0] rd, output logic [1:0] oe);
    int n;
    begin
      n = 0;
      @(posedge clk_sys);
      #1;
      reg_n = !io;
      {ce2_n, ce1_n} = ce;
      addr = a;
      data_in = wd;
      {iowr_n, iord_n, we_n, oe_n} = ~(4'h1 << {io, wr});
      repeat (2) @(posedge clk_sys);
      #1;
      // hold everything while the device stretches the cycle
      while (wait_n !== 1'b1 && n < 50)
      begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      if (n == 50)
        hangs++;
      rd = data_out;
      oe = data_oe_n;
      {iowr_n, iord_n, we_n, oe_n} = 4'hf;
      {ce2_n, ce1_n} = 2'b11;
      addr = ~a;
      data_in = ~wd;
      repeat (3) @(posedge clk_sys);
      #1;
    end
  endtask
endmodule

`default_nettype wire

//--- testbench/task_file_address_decoder_tb.sv
// self-checking bench for the task file address decoder
`timescale 1ns/1ps
`default_nettype none

module task_file_address_decoder_tb;
  localparam logic [7:0] ERR_VAL = 8'h5a;
  localparam logic [7:0] STS_VAL = 8'h50;
  localparam logic [7:0] DRV_VAL = 8'hc3;
  logic clk_sys, arst_n, ide_mode_select_pin, reg_n, ce1_n, ce2_n, oe_n, we_n, iord_n, iowr_n;
  logic wait_n, command_strobe, wrbuf_valid, wrbuf_ready, rdbuf_valid, rdbuf_ready;
  logic [5:0] config_index;
  logic [10:0] addr;
  logic [15:0] data_in, data_out, wrbuf_data, rdbuf_data;
  logic [1:0] data_oe_n;
  logic [7:0] feature, sector_count, sector_number, cyl_low, cyl_high, drive_head_select;
  logic [7:0] device_control, command_code;
  logic [15:0] words [4] = '{16'hb7a4, 16'h3c19, 16'h6e2d, 16'h58f0};
  int num_errors, checked, hangs, n;

  task_file_address_decoder dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .config_index(config_index),
    .ide_mode_select_pin(ide_mode_select_pin), .reg_n(reg_n), .ce1_n(ce1_n), .ce2_n(ce2_n),
    .oe_n(oe_n), .we_n(we_n), .iord_n(iord_n), .iowr_n(iowr_n), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .wait_n(wait_n), .error_code(ERR_VAL),
    .status_code(STS_VAL), .drive_address(DRV_VAL), .feature(feature), .sector_count(sector_count),
    .sector_number(sector_number), .cyl_low(cyl_low), .cyl_high(cyl_high),
    .drive_head_select(drive_head_select), .device_control(device_control),
    .command_code(command_code), .command_strobe(command_strobe), .wrbuf_valid(wrbuf_valid),
    .wrbuf_ready(wrbuf_ready), .wrbuf_data(wrbuf_data), .rdbuf_valid(rdbuf_valid),
    .rdbuf_ready(rdbuf_ready), .rdbuf_data(rdbuf_data));

  host_socket_model host_u (.clk_sys(clk_sys), .wait_n(wait_n), .data_out(data_out),
    .data_oe_n(data_oe_n), .reg_n(reg_n), .ce1_n(ce1_n), .ce2_n(ce2_n), .oe_n(oe_n), .we_n(we_n),
    .iord_n(iord_n), .iowr_n(iowr_n), .addr(addr), .data_in(data_in), .hangs(hangs));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // checking tasks
  // ----------------------------------------
  task automatic tally_and_finish;
    begin
      num_errors += hangs;
      $display("errors %0d, checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      checked++;
      if (got !== exp)
      begin
        num_errors++;
        $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // lane enables are always compared; data only when something is driven
  task automatic rd(input logic io, input logic [1:0] ce, input logic [10:0] a,
      input logic [15:0] ed, input logic [1:0] eo);
    logic [15:0] d;
    logic [1:0] o;
    begin
      host_u.access(io, 1'b0, ce, a, 16'h0000, d, o);
      chk({14'h0000, o}, {14'h0000, eo});
      if (eo != 2'b11)
        chk(d, ed);
    end
  endtask

  task automatic wr(input logic io, input logic [1:0] ce, input logic [10:0] a, input logic [15:0] wd);
    logic [15:0] d;
    logic [1:0] o;
    begin
      host_u.access(io, 1'b1, ce, a, wd, d, o);
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    num_errors = 0;
    checked = 0;
    arst_n = 1'b0;
    config_index = 6'h00;
    ide_mode_select_pin = 1'b1;
    rdbuf_valid = 1'b0;
    rdbuf_data = 16'h0000;
    wrbuf_ready = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    chk({14'h0000, data_oe_n}, 16'h0003);
    rd(1'b1, 2'b10, 11'h1f7, 16'h0000, 2'b11);
    config_index = 6'h02;
    wr(1'b1, 2'b10, 11'h1f2, 16'h0027);
    chk({8'h00, sector_count}, 16'h0027);
    wr(1'b1, 2'b10, 11'h1f7, 16'h00ec);
    chk({8'h00, command_code}, 16'h00ec);
    wr(1'b1, 2'b10, 11'h5f4, 16'h0081);
    chk({8'h00, cyl_low}, 16'h0081);
    rd(1'b1, 2'b10, 11'h1f7, {STS_VAL, STS_VAL}, 2'b10);
    rd(1'b1, 2'b10, 11'h3f6, {STS_VAL, STS_VAL}, 2'b10);
    rd(1'b1, 2'b10, 11'h1f8, 16'h0000, 2'b11);
    rd(1'b1, 2'b11, 11'h1f1, 16'h0000, 2'b11);
    config_index = 6'h03;
    rd(1'b1, 2'b10, 11'h177, {STS_VAL, STS_VAL}, 2'b10);
    rd(1'b1, 2'b10, 11'h1f7, 16'h0000, 2'b11);
    config_index = 6'h01;
    wr(1'b1, 2'b10, 11'h7f3, 16'h0044);
    chk({8'h00, sector_number}, 16'h0044);
    rd(1'b1, 2'b10, 11'h02f, {DRV_VAL, DRV_VAL}, 2'b10);
    rd(1'b1, 2'b10, 11'h00d, {ERR_VAL, ERR_VAL}, 2'b10);
    rd(1'b1, 2'b10, 11'h00b, 16'h0000, 2'b11);
    // engine stalls so the queued word stays visible
    wrbuf_ready = 1'b0;
    wr(1'b1, 2'b00, 11'h000, 16'h9e61);
    n = 0;
    while (wrbuf_valid !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 20)
    begin
      num_errors++;
      tally_and_finish();
    end
    chk(wrbuf_data, 16'h9e61);
    wrbuf_ready = 1'b1;
    // memory mode: the engine preloads the read buffer
    config_index = 6'h00;
    rdbuf_valid = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      rdbuf_data = words[i];
      @(posedge clk_sys);
      #1;
    end
    rdbuf_valid = 1'b0;
    wr(1'b0, 2'b10, 11'h002, 16'h0033);
    chk({8'h00, sector_count}, 16'h0033);
    rd(1'b0, 2'b10, 11'h400, 16'ha4a4, 2'b10);
    rd(1'b0, 2'b10, 11'h401, 16'hb7b7, 2'b10);
    rd(1'b0, 2'b00, 11'h7fe, 16'h3c19, 2'b00);
    rd(1'b0, 2'b10, 11'h008, 16'h2d2d, 2'b10);
    rd(1'b0, 2'b01, 11'h009, 16'h6e6e, 2'b01);
    rd(1'b0, 2'b10, 11'h000, 16'hf0f0, 2'b10);
    ide_mode_select_pin = 1'b0;
    wr(1'b1, 2'b10, 11'h7fb, 16'h0066);
    chk({8'h00, sector_number}, 16'h0066);
    rd(1'b1, 2'b10, 11'h00f, {STS_VAL, STS_VAL}, 2'b10);
    rd(1'b1, 2'b01, 11'h003, 16'h0000, 2'b11);
    tally_and_finish();
  end
endmodule

`default_nettype wire

//--- verilog/task_data_fifo.sv
// synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none

module task_data_fifo
  import tf_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_COUNT = AW'(DEPTH) == '0 ? {1'b1, {AW{1'b0}}} : {1'b0, AW'(DEPTH)};

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] count;
  } fifo_s;

  fifo_s st;
  fifo_s next_st;
  logic do_push;
  logic do_pop;

  assign in_ready = (st.count != FULL_COUNT);
  assign out_valid = (st.count != '0);
  assign out_data = st.mem[st.rp];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  always_comb
  begin
    next_st = st;
    if (do_push)
    begin
      next_st.mem[st.wp] = in_data;
      next_st.wp = (st.wp == AW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
    end
    if (do_pop)
      next_st.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
    if (do_push && !do_pop)
      next_st.count = st.count + 1'b1;
    else if (do_pop && !do_push)
      next_st.count = st.count - 1'b1;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else
      st <= next_st;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_fifo_fill_bound: assert property (st.count <= FULL_COUNT)
    else $error("fifo count above depth");
  a_fifo_push_count: assert property (do_push && !do_pop |=> st.count == $past(st.count) + 1'b1)
    else $error("fifo push did not raise count");

endmodule

`default_nettype wire

//--- verilog/task_file_address_decoder.sv
// task file register decode, byte lane steering and data buffering
//
// Function
// - config index selects the mapping scheme
// - index zero: memory only, i/o ignored
// - memory mode: 2k window at offset zero
// - offsets 400-7ff all reach data fifo
// - even data byte read fetches next word
// - odd data byte returns held high byte
// - primary/secondary ranges, a9-a0 decoded, a10 ignored
// - primary/secondary aliases every 1k of i/o
// - contiguous mode decodes only a3-a0
// - local offsets 0-7, e and f
// - contiguous and memory modes add duplicates at 8, 9, d
// - data register readable as one word
// - true ide decodes only a2-a0
// - true ide: ce1 task regs, ce2 control
`timescale 1ns/1ps
`default_nettype none

`include "tf_defines.svh"

module task_file_address_decoder
  import tf_pkg::*;
#(
  parameter int FIFO_DEPTH = `DATA_FIFO_DEPTH
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [5:0] config_index,
  input wire logic ide_mode_select_pin,
  input wire logic reg_n,
  input wire logic ce1_n,
  input wire logic ce2_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic iord_n,
  input wire logic iowr_n,
  input wire logic [10:0] addr,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic [1:0] data_oe_n,
  output logic wait_n,
  input wire logic [7:0] error_code,
  input wire logic [7:0] status_code,
  input wire logic [7:0] drive_address,
  output logic [7:0] feature,
  output logic [7:0] sector_count,
  output logic [7:0] sector_number,
  output logic [7:0] cyl_low,
  output logic [7:0] cyl_high,
  output logic [7:0] drive_head_select,
  output logic [7:0] device_control,
  output logic [7:0] command_code,
  output logic command_strobe,
  output logic wrbuf_valid,
  input wire logic wrbuf_ready,
  output logic [15:0] wrbuf_data,
  input wire logic rdbuf_valid,
  output logic rdbuf_ready,
  input wire logic [15:0] rdbuf_data
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic map_mode_e pick_mode(input logic ide_n, input logic [5:0] cfg);
    if (!ide_n)
      pick_mode = MAP_TRUE_IDE;
    else
      unique case (cfg)
        `CFG_IDX_MEMORY: pick_mode = MAP_MEMORY;
        `CFG_IDX_CONTIG: pick_mode = MAP_CONTIG;
        `CFG_IDX_PRIMARY: pick_mode = MAP_PRIMARY;
        `CFG_IDX_SECONDARY: pick_mode = MAP_SECONDARY;
        default: pick_mode = MAP_NONE;
      endcase
  endfunction

  function automatic logic is_even_data(input logic [3:0] i);
    is_even_data = (i == `TF_IDX_DATA) || (i == `TF_IDX_EVEN_DATA);
  endfunction

  function automatic logic is_data(input logic [3:0] i);
    is_data = is_even_data(i) || (i == `TF_IDX_ODD_DATA);
  endfunction

  function automatic logic [7:0] get_byte(input tf_s s, input logic [3:0] i, input logic [15:0] head,
                                          input logic [7:0] err, input logic [7:0] sts,
                                          input logic [7:0] drv);
    unique case (i)
      `TF_IDX_DATA, `TF_IDX_EVEN_DATA: get_byte = head[7:0];
      `TF_IDX_ODD_DATA: get_byte = s.high_hold;
      `TF_IDX_ERROR, `TF_IDX_ERROR_DUP: get_byte = err;
      `TF_IDX_SECT_CNT: get_byte = s.sector_count;
      `TF_IDX_SECT_NUM: get_byte = s.sector_number;
      `TF_IDX_CYL_LOW: get_byte = s.cyl_low;
      `TF_IDX_CYL_HIGH: get_byte = s.cyl_high;
      `TF_IDX_DRV_HEAD: get_byte = s.drive_head;
      `TF_IDX_STATUS, `TF_IDX_ALT_STATUS: get_byte = sts;
      `TF_IDX_DRV_ADDR: get_byte = drv;
      default: get_byte = `TF_RESET_BYTE;
    endcase
  endfunction

  function automatic tf_s put_byte(input tf_s s, input logic [3:0] i, input logic [7:0] b);
    tf_s r;
    r = s;
    unique case (i)
      `TF_IDX_ERROR, `TF_IDX_ERROR_DUP: r.feature = b;
      `TF_IDX_SECT_CNT: r.sector_count = b;
      `TF_IDX_SECT_NUM: r.sector_number = b;
      `TF_IDX_CYL_LOW: r.cyl_low = b;
      `TF_IDX_CYL_HIGH: r.cyl_high = b;
      `TF_IDX_DRV_HEAD: r.drive_head = b;
      `TF_IDX_STATUS:
      begin
        r.command = b;
        r.cmd_strobe = 1'b1;
      end
      `TF_IDX_ALT_STATUS: r.device_control = b;
      default: r = s;
    endcase
    put_byte = r;
  endfunction

  // ----------------------------------------------------------------
  // decode and strobes
  // ----------------------------------------------------------------
  map_mode_e mode;
  logic hit;
  logic [3:0] idx;
  logic lane_lo;
  logic lane_hi;
  logic rd_act;
  logic wr_act;
  logic rd_head_valid;
  logic [15:0] rd_head;
  logic rd_pop;
  logic wr_in_ready;

  assign mode = pick_mode(ide_mode_select_pin, config_index);

  task_file_decode u_decode (
    .mode(mode),
    .ce1_n(ce1_n),
    .ce2_n(ce2_n),
    .addr(addr),
    .hit(hit),
    .idx(idx),
    .lane_lo(lane_lo),
    .lane_hi(lane_hi)
  );

  // memory cycles use oe/we with reg high; i/o cycles need reg low except in true ide mode
  always_comb
  begin
    unique case (mode)
      MAP_MEMORY:
      begin
        rd_act = hit && !oe_n && reg_n;
        wr_act = hit && !we_n && reg_n;
      end
      MAP_TRUE_IDE:
      begin
        rd_act = hit && !iord_n;
        wr_act = hit && !iowr_n;
      end
      MAP_NONE:
      begin
        rd_act = 1'b0;
        wr_act = 1'b0;
      end
      default:
      begin
        rd_act = hit && !iord_n && !reg_n;
        wr_act = hit && !iowr_n && !reg_n;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state update
  // ----------------------------------------------------------------
  tf_s st;
  tf_s next_st;
  logic rd_start;
  logic wr_end;

  always_comb
  begin
    next_st = st;
    next_st.cmd_strobe = 1'b0;
    next_st.push_valid = st.push_valid && !wr_in_ready;
    next_st.wait_n = 1'b1;
    rd_pop = 1'b0;
    rd_start = 1'b0;
    wr_end = 1'b0;
    unique case (st.phase)
      PH_IDLE:
      begin
        if (rd_act)
        begin
          if (is_even_data(idx) && !rd_head_valid)
            next_st.wait_n = 1'b0;
          else
          begin
            rd_start = 1'b1;
            next_st.phase = PH_READ;
            next_st.data_oe_n = {!lane_hi, !lane_lo};
            if (is_even_data(idx))
            begin
              rd_pop = 1'b1;
              next_st.high_hold = rd_head[15:8];
            end
            if (is_even_data(idx) && lane_lo && lane_hi)
              next_st.data_out = rd_head;
            else if (lane_lo && lane_hi)
              next_st.data_out = {get_byte(st, {idx[3:1], 1'b1}, rd_head, error_code, status_code,
                                           drive_address),
                                  get_byte(st, idx, rd_head, error_code, status_code, drive_address)};
            else
              begin
                next_st.data_out[7:0] = get_byte(st, idx, rd_head, error_code, status_code,
                                                 drive_address);
                next_st.data_out[15:8] = next_st.data_out[7:0];
              end
          end
        end
        else if (wr_act)
        begin
          next_st.phase = PH_WRITE;
          next_st.idx = idx;
          next_st.lane_lo = lane_lo;
          next_st.lane_hi = lane_hi;
          next_st.wdata = data_in;
        end
      end
      PH_READ:
      begin
        if (!rd_act)
        begin
          next_st.phase = PH_IDLE;
          next_st.data_oe_n = `LANES_FLOAT;
        end
      end
      PH_WRITE:
      begin
        if (wr_act)
        begin
          next_st.wdata = data_in;
          if (is_data(st.idx) && (st.push_valid || !wr_in_ready))
            next_st.wait_n = 1'b0;
        end
        else
        begin
          wr_end = 1'b1;
          next_st.phase = PH_IDLE;
          if (is_even_data(st.idx) && st.lane_lo && st.lane_hi)
          begin
            next_st.push_valid = 1'b1;
            next_st.push_data = st.wdata;
          end
          else if (is_even_data(st.idx))
            next_st.low_hold = st.wdata[7:0];
          else if (st.idx == `TF_IDX_ODD_DATA)
          begin
            next_st.push_valid = 1'b1;
            next_st.push_data = {st.lane_hi ? st.wdata[15:8] : st.wdata[7:0], st.low_hold};
          end
          else if (st.lane_lo && st.lane_hi)
          begin
            next_st = put_byte(next_st, st.idx, st.wdata[7:0]);
            next_st = put_byte(next_st, {st.idx[3:1], 1'b1}, st.wdata[15:8]);
          end
          else if (st.lane_hi)
            next_st = put_byte(next_st, st.idx, st.wdata[15:8]);
          else
            next_st = put_byte(next_st, st.idx, st.wdata[7:0]);
        end
      end
      default:
        next_st.phase = PH_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
      st.phase <= PH_IDLE;
      st.data_oe_n <= `LANES_FLOAT;
      st.wait_n <= 1'b1;
    end
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // buffers
  // ----------------------------------------------------------------
  // host writes are queued so the engine may drain at its own pace
  task_data_fifo #(.WIDTH(`DATA_WORD_WIDTH), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_valid(st.push_valid),
    .in_ready(wr_in_ready),
    .in_data(st.push_data),
    .out_valid(wrbuf_valid),
    .out_ready(wrbuf_ready),
    .out_data(wrbuf_data)
  );

  task_data_fifo #(.WIDTH(`DATA_WORD_WIDTH), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_valid(rdbuf_valid),
    .in_ready(rdbuf_ready),
    .in_data(rdbuf_data),
    .out_valid(rd_head_valid),
    .out_ready(rd_pop),
    .out_data(rd_head)
  );

  assign data_out = st.data_out;
  assign data_oe_n = st.data_oe_n;
  assign wait_n = st.wait_n;
  assign feature = st.feature;
  assign sector_count = st.sector_count;
  assign sector_number = st.sector_number;
  assign cyl_low = st.cyl_low;
  assign cyl_high = st.cyl_high;
  assign drive_head_select = st.drive_head;
  assign device_control = st.device_control;
  assign command_code = st.command;
  assign command_strobe = st.cmd_strobe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_write_end;
    st.phase == PH_WRITE && !wr_act;
  endsequence

  a_float_no_enable: assert property (ce1_n && ce2_n |=> data_oe_n == `LANES_FLOAT)
    else $error("bus driven with no chip enable");
  a_io_off_memory: assert property (mode == MAP_MEMORY && !iord_n && !reg_n |-> !rd_act)
    else $error("i/o read taken in memory-only mode");
  a_mem_data_window: assert property (mode == MAP_MEMORY && hit && addr[`MEM_WINDOW_BIT]
                                      |-> is_data(idx))
    else $error("memory window did not reach data");
  a_primary_alias: assert property (mode == MAP_PRIMARY && !ce1_n && addr[9:0] == 10'h1f7
                                    |-> hit && idx == `TF_IDX_STATUS)
    else $error("primary status alias missed");
  a_ide_ce2_ctl: assert property (mode == MAP_TRUE_IDE && ce1_n && !ce2_n && addr[2:0] == 3'h6
                                  |-> hit && idx == `TF_IDX_ALT_STATUS)
    else $error("true ide control register missed");
  a_contig_dup: assert property (mode == MAP_CONTIG && !ce1_n && ce2_n && addr[3:0] == 4'h9
                                 |-> hit && idx == `TF_IDX_ODD_DATA)
    else $error("contiguous odd duplicate missed");
  a_command_pulse: assert property (s_write_end ##0 (st.idx == `TF_IDX_STATUS && st.lane_lo
                                     && !st.lane_hi) |=> command_strobe
                                     && command_code == $past(st.wdata[7:0]) ##1 !command_strobe)
    else $error("command write did not pulse");
  a_word_push: assert property (s_write_end ##0 (is_even_data(st.idx) && st.lane_lo && st.lane_hi)
                                |=> st.push_valid && st.push_data == $past(st.wdata))
    else $error("word write not queued");
  a_hi_lane_read: assert property (st.phase == PH_IDLE && rd_start && ce1_n && !ce2_n
                                   && mode != MAP_TRUE_IDE |=> data_oe_n == `LANES_HIGH_ONLY)
    else $error("odd byte not on upper lanes");

endmodule

`default_nettype wire

//--- verilog/task_file_decode.sv
// maps host address and chip enables onto a local task file index
`timescale 1ns/1ps
`default_nettype none

`include "tf_defines.svh"

module task_file_decode
  import tf_pkg::*;
(
  input wire map_mode_e mode,
  input wire logic ce1_n,
  input wire logic ce2_n,
  input wire logic [10:0] addr,
  output logic hit,
  output logic [3:0] idx,
  output logic lane_lo,
  output logic lane_hi
);

  // offsets a-c hold nothing in the local sixteen byte map
  function automatic logic local_valid(input logic [3:0] a);
    local_valid = !(a >= 4'ha && a <= 4'hc);
  endfunction

  logic [5:0] base_task;
  logic [5:0] base_ctl;

  always_comb
  begin
    base_task = (mode == MAP_SECONDARY) ? `IO_BASE_SEC_TASK : `IO_BASE_PRI_TASK;
    base_ctl = (mode == MAP_SECONDARY) ? `IO_BASE_SEC_CTL : `IO_BASE_PRI_CTL;
    hit = 1'b0;
    idx = addr[3:0];
    lane_lo = !ce1_n;
    lane_hi = !ce2_n;
    unique case (mode)
      MAP_MEMORY:
      begin
        if (addr[`MEM_WINDOW_BIT])
        begin
          hit = 1'b1;
          idx = addr[0] ? `TF_IDX_ODD_DATA : `TF_IDX_EVEN_DATA;
        end
        else if (addr[9:4] == `LOCAL_ZERO_HI)
          hit = local_valid(addr[3:0]);
      end
      MAP_CONTIG:
        hit = local_valid(addr[3:0]);
      MAP_PRIMARY, MAP_SECONDARY:
      begin
        // bit 10 is never looked at, so aliases repeat up the i/o space
        if (addr[9:4] == base_task && !addr[3])
        begin
          hit = 1'b1;
          idx = {1'b0, addr[2:0]};
        end
        else if (addr[9:4] == base_ctl && addr[3:1] == `CTL_PAIR)
        begin
          hit = 1'b1;
          idx = {1'b1, addr[2:0]};
        end
      end
      MAP_TRUE_IDE:
      begin
        if (!ce1_n && ce2_n)
        begin
          hit = 1'b1;
          idx = {1'b0, addr[2:0]};
          lane_lo = 1'b1;
          lane_hi = (addr[2:0] == 3'h0);
        end
        else if (ce1_n && !ce2_n && addr[2:1] == `IDE_CTL_PAIR)
        begin
          hit = 1'b1;
          idx = {1'b1, addr[2:0]};
          lane_lo = 1'b1;
          lane_hi = 1'b0;
        end
      end
      MAP_NONE:
        hit = 1'b0;
    endcase
    // outside true ide, an upper-lane-only access always names the odd byte
    if (mode != MAP_TRUE_IDE && ce1_n && !ce2_n)
      idx[0] = 1'b1;
    if (ce1_n && ce2_n)
      hit = 1'b0;
  end

endmodule

`default_nettype wire

//--- verilog/tf_defines.svh
// constants for the task file address decoder
`ifndef TF_DEFINES_SVH
`define TF_DEFINES_SVH

// configuration index values written by the host
`define CFG_IDX_MEMORY 6'h00
`define CFG_IDX_CONTIG 6'h01
`define CFG_IDX_PRIMARY 6'h02
`define CFG_IDX_SECONDARY 6'h03

// local register indices
`define TF_IDX_DATA 4'h0
`define TF_IDX_ERROR 4'h1
`define TF_IDX_SECT_CNT 4'h2
`define TF_IDX_SECT_NUM 4'h3
`define TF_IDX_CYL_LOW 4'h4
`define TF_IDX_CYL_HIGH 4'h5
`define TF_IDX_DRV_HEAD 4'h6
`define TF_IDX_STATUS 4'h7
`define TF_IDX_EVEN_DATA 4'h8
`define TF_IDX_ODD_DATA 4'h9
`define TF_IDX_ERROR_DUP 4'hd
`define TF_IDX_ALT_STATUS 4'he
`define TF_IDX_DRV_ADDR 4'hf

// address decode fields
`define MEM_WINDOW_BIT 10
`define IO_BASE_PRI_TASK 6'h1f
`define IO_BASE_PRI_CTL 6'h3f
`define IO_BASE_SEC_TASK 6'h17
`define IO_BASE_SEC_CTL 6'h37
`define LOCAL_ZERO_HI 6'h00
`define CTL_PAIR 3'b011
`define IDE_CTL_PAIR 2'b11

// reset values and lane enable codes
`define TF_RESET_BYTE 8'h00
`define TF_RESET_WORD 16'h0000
`define LANES_FLOAT 2'b11
`define LANES_LOW_ONLY 2'b10
`define LANES_HIGH_ONLY 2'b01

// buffering
`define DATA_FIFO_DEPTH 16
`define DATA_WORD_WIDTH 16

`endif

//--- verilog/tf_pkg.sv
// types shared by the task file address decoder
package tf_pkg;

  typedef enum logic [2:0] {
    MAP_MEMORY,
    MAP_CONTIG,
    MAP_PRIMARY,
    MAP_SECONDARY,
    MAP_TRUE_IDE,
    MAP_NONE
  } map_mode_e;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_READ,
    PH_WRITE
  } phase_e;

  typedef struct packed {
    phase_e phase;
    logic [3:0] idx;
    logic lane_lo;
    logic lane_hi;
    logic [15:0] wdata;
    logic [7:0] feature;
    logic [7:0] sector_count;
    logic [7:0] sector_number;
    logic [7:0] cyl_low;
    logic [7:0] cyl_high;
    logic [7:0] drive_head;
    logic [7:0] command;
    logic [7:0] device_control;
    logic cmd_strobe;
    logic [7:0] low_hold;
    logic [7:0] high_hold;
    logic push_valid;
    logic [15:0] push_data;
    logic [15:0] data_out;
    logic [1:0] data_oe_n;
    logic wait_n;
  } tf_s;

endpackage
